// [design/core_clock_out_pkg.sv]
// constants for the internal oscillator and system clock divider
//
// What this block does
// - reset selects internal oscillator as clock source
// - sources: external, internal full, internal divided
// - divide field picks 8, 4, 2, 1
// - divide field resets to zero, divide eight
// - control bit 7 enables internal oscillator
// - read-only bit 6 shows oscillator ready
// - calibration register holds factory period value
// - source bit 0 picks internal or external
`default_nettype none
package core_clock_out_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_ADDR    = 8'hB2;
	localparam logic [7:0] CAL_ADDR     = 8'hB3;
	localparam logic [7:0] SRC_ADDR     = 8'hA9;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int         ENABLE_BIT   = 7;
	localparam int         READY_BIT    = 6;
	localparam int         SRC_BIT      = 0;
	localparam logic [7:0] CTRL_RESET   = 8'hC0;
	localparam logic [7:0] CAL_RESET    = 8'h80;
	localparam logic [7:0] SRC_RESET    = 8'h00;
	// ------------------------------------------------------------
	// divide encodings and timing
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DIV_8 = 2'b00,
		DIV_4 = 2'b01,
		DIV_2 = 2'b10,
		DIV_1 = 2'b11
	} div_sel_t;
	localparam logic [2:0] SETTLE_CYCLES = 3'h4;
	// counter reload per divide setting, period minus one
	localparam logic [2:0] LOAD_DIV_8    = 3'h7;
	localparam logic [2:0] LOAD_DIV_4    = 3'h3;
	localparam logic [2:0] LOAD_DIV_2    = 3'h1;
	localparam logic [2:0] LOAD_DIV_1    = 3'h0;
endpackage
`default_nettype wire

// [design/core_clock_out_ctrl.sv]
// internal oscillator control, calibration and system clock divider
`default_nettype none
module core_clock_out_ctrl
	import core_clock_out_pkg::*;
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// special function register port
	input  wire logic [7:0] sfr_addr_in,
	input  wire logic       sfr_wr_in,
	input  wire logic [7:0] sfr_wdata_in,
	input  wire logic       sfr_rd_in,
	output logic      [7:0] sfr_rdata_out,
	// external oscillator pin
	input  wire logic       ext_osc_in,
	// clock to core and peripherals, and the calibration value
	output logic            core_clock_out,
	output logic      [7:0] internal_osc_calibration_out
);
	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic       internal_osc_enable;
	div_sel_t   internal_osc_divide_select;
	logic [7:0] internal_osc_calibration;
	logic       clock_source_select;
	logic       internal_osc_ready_flag;
	logic [2:0] settle;
	logic       ext_s1;
	logic       ext_s2;
	logic       ext_s3;
	logic       ext_rise;
	logic       active_src;
	div_sel_t   active_div;
	logic [2:0] cnt;
	logic [2:0] next_cnt;
	logic       boundary;

	wire wr_ctrl = sfr_wr_in && sfr_addr_in == CTRL_ADDR;
	wire wr_cal  = sfr_wr_in && sfr_addr_in == CAL_ADDR;
	wire wr_src  = sfr_wr_in && sfr_addr_in == SRC_ADDR;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			internal_osc_enable        <= CTRL_RESET[ENABLE_BIT];
			internal_osc_divide_select <= div_sel_t'(CTRL_RESET[1:0]);
		end else if (wr_ctrl) begin
			internal_osc_enable        <= sfr_wdata_in[ENABLE_BIT];
			internal_osc_divide_select <= div_sel_t'(sfr_wdata_in[1:0]);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			internal_osc_calibration <= CAL_RESET;
		else if (wr_cal)
			internal_osc_calibration <= sfr_wdata_in;
	end
	assign internal_osc_calibration_out = internal_osc_calibration;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			clock_source_select <= SRC_RESET[SRC_BIT];
		else if (wr_src)
			clock_source_select <= sfr_wdata_in[SRC_BIT];
	end

	// ------------------------------------------------------------
	// ready flag
	// ------------------------------------------------------------
	// a new period setting restarts the settle wait
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			settle                  <= 3'h0;
			internal_osc_ready_flag <= CTRL_RESET[READY_BIT];
		end else if (!internal_osc_enable || wr_cal) begin
			settle                  <= SETTLE_CYCLES;
			internal_osc_ready_flag <= 1'b0;
		end else if (settle != 3'h0) begin
			settle                  <= settle - 3'h1;
			internal_osc_ready_flag <= 1'b0;
		end else begin
			internal_osc_ready_flag <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// external pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			ext_s1 <= ext_osc_in;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	assign ext_rise = ext_s2 && !ext_s3;

	// ------------------------------------------------------------
	// divider and source switch
	// ------------------------------------------------------------
	// settings move only at a period boundary, so no short phase;
	// output is one clock-wide tick per system clock period
	assign boundary = active_src || !internal_osc_enable || cnt == 3'h0;

	always_comb begin
		case (internal_osc_divide_select)
			DIV_8:   next_cnt = LOAD_DIV_8;
			DIV_4:   next_cnt = LOAD_DIV_4;
			DIV_2:   next_cnt = LOAD_DIV_2;
			default: next_cnt = LOAD_DIV_1;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			active_src <= SRC_RESET[SRC_BIT];
			active_div <= div_sel_t'(CTRL_RESET[1:0]);
		end else if (boundary) begin
			active_src <= clock_source_select;
			active_div <= internal_osc_divide_select;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			cnt <= 3'h0;
		else if (boundary)
			cnt <= next_cnt;
		else
			cnt <= cnt - 3'h1;
	end

	// software must pick only a settled source; no hardware guard
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			core_clock_out <= 1'b0;
		else if (clock_source_select && active_src)
			core_clock_out <= ext_rise;
		else
			core_clock_out <= !active_src && internal_osc_enable
				&& cnt == 3'h0;
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_b_in)
			sfr_rdata_out <= 8'h00;
		else if (sfr_rd_in) begin
			if (sfr_addr_in == CTRL_ADDR)
				sfr_rdata_out <= {internal_osc_enable,
					internal_osc_ready_flag, 4'h0,
					internal_osc_divide_select};
			else if (sfr_addr_in == CAL_ADDR)
				sfr_rdata_out <= internal_osc_calibration;
			else if (sfr_addr_in == SRC_ADDR)
				sfr_rdata_out <= {7'h00, clock_source_select};
			else
				sfr_rdata_out <= 8'h00;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	reset_source_a: assert property (@(posedge clk_in)
		$rose(rst_b_in) |-> !clock_source_select && !active_src)
		else $error("source not internal after reset");
	reset_divide_a: assert property (@(posedge clk_in)
		$rose(rst_b_in) |-> internal_osc_divide_select == DIV_8
			&& internal_osc_enable)
		else $error("divide not eight after reset");
	div_eight_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		core_clock_out && !active_src && active_div == DIV_8
			&& !wr_ctrl && internal_osc_divide_select == DIV_8
			|=> !core_clock_out [*7] ##1 core_clock_out)
		else $error("divide by eight period wrong");
	div_one_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		!active_src && active_div == DIV_1 && internal_osc_enable
			&& !clock_source_select |=> core_clock_out)
		else $error("divide by one not continuous");
	enable_write_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_ctrl |=> internal_osc_enable == $past(sfr_wdata_in[7]))
		else $error("enable bit not stored");
	ready_flag_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		!internal_osc_enable |=> !internal_osc_ready_flag)
		else $error("ready while disabled");
	cal_write_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_cal |=> !internal_osc_ready_flag [*5]
			##1 (internal_osc_ready_flag || !internal_osc_enable
			|| settle != 3'h0))
		else $error("ready not held off after calibration");
	source_switch_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		wr_src && sfr_wdata_in[0] && !wr_ctrl && !wr_cal
			|-> ##[1:9] active_src)
		else $error("external source not taken");
	no_short_phase_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		$changed(active_div) |-> $past(boundary))
		else $error("divide changed mid period");
	div_four_a: assert property (@(posedge clk_in)
		disable iff (!rst_b_in)
		core_clock_out && !active_src && active_div == DIV_4
			&& internal_osc_enable |=> !core_clock_out [*3])
		else $error("divide by four period short");
	reset_tick_a: assert property (@(posedge clk_in)
		!rst_b_in |=> !core_clock_out)
		else $error("tick during reset");
endmodule
`default_nettype wire

// [bench/clk_sink.sv]
// consumer model: measures the spacing of system clock ticks
`default_nettype none
module clk_sink (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	// tick from the block
	input  wire logic       core_clock_in,
	// spacing of the last two ticks and tick count
	output logic      [7:0] gap_out,
	output logic      [7:0] ticks_out
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] since;
	// tick used as a clock enable, as the core would
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			since <= 8'h00;
			gap_out <= 8'h00;
			ticks_out <= 8'h00;
		end else if (core_clock_in) begin
			gap_out <= since + 8'h01;
			since <= 8'h00;
			ticks_out <= ticks_out + 8'h01;
		end else begin
			since <= since + 8'h01;
		end
	end
endmodule
`default_nettype wire

// [bench/tb.sv]
// self-checking bench for the clock control block
`default_nettype none
module tb
	import core_clock_out_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic        wr = 1'b0;
	logic [7:0]  wdata = 8'h00;
	logic        rd = 1'b0;
	logic        ext = 1'b0;
	logic [7:0]  rdata, cal, gap, ticks, t0;
	logic        tick;
	logic [7:0]  last_gap = 8'h08;
	int          miscompares = 0;
	int          checks = 0;
	// control value written, tick spacing expected
	logic [15:0] rows [4] = '{16'hFC08, 16'hFD04, 16'hFE02, 16'hFF01};
	always #20 clk_in = ~clk_in;
	// external oscillator, 10 clocks a period, phase unrelated
	initial begin
		#7;
		forever #200 ext = ~ext;
	end
	core_clock_out_ctrl u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata),
		.sfr_rd_in(rd), .sfr_rdata_out(rdata), .ext_osc_in(ext),
		.core_clock_out(tick), .internal_osc_calibration_out(cal));
	clk_sink u_sink (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.core_clock_in(tick), .gap_out(gap), .ticks_out(ticks));
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic settle(int n);
		repeat (n) @(negedge clk_in);
	endtask
	// bus tasks enter and leave at a falling edge
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		settle(1);
		wr = 1'b0;
	endtask
	task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		settle(1);
		rd = 1'b0;
		settle(1);
		check("read data", rdata, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// hang guard; every wait below is a fixed count except the tick wait, which stops after at most 20 clocks
	initial begin
		#200000;
		miscompares++;
		tally_and_finish();
	end
	initial begin
		settle(5);
		rst_b_in = 1'b1;
		rd_chk(CTRL_ADDR, 8'hC0);
		rd_chk(CAL_ADDR, 8'h80);
		check("calibration", cal, CAL_RESET);
		rd_chk(SRC_ADDR, 8'h00);
		settle(20);
		check("gap", gap, 8'h08);
		for (int i = 0; i < 4; i++) begin
			wr_reg(CTRL_ADDR, rows[i][15:8]);
			// first tick after the write still closes the old period
			t0 = ticks;
			for (int n = 0; n < 20 && ticks == t0; n++)
				settle(1);
			check("tick seen", {7'h00, ticks != t0}, 8'h01);
			check("first gap", gap, last_gap);
			settle(20);
			check("gap", gap, rows[i][7:0]);
			rd_chk(CTRL_ADDR, rows[i][15:8] & 8'hC3);
			last_gap = rows[i][7:0];
		end
		// unmapped place: reads zero, write lands nowhere
		wr_reg(8'h55, 8'h00);
		rd_chk(8'h55, 8'h00);
		rd_chk(CTRL_ADDR, 8'hC3);
		// new period: ready drops until it settles again
		wr_reg(CAL_ADDR, 8'h5A);
		rd_chk(CTRL_ADDR, 8'h83);
		check("calibration", cal, 8'h5A);
		settle(10);
		rd_chk(CTRL_ADDR, 8'hC3);
		wr_reg(CTRL_ADDR, 8'h03);
		settle(2);
		t0 = ticks;
		settle(20);
		check("ticks", ticks, t0);
		rd_chk(CTRL_ADDR, 8'h03);
		wr_reg(CTRL_ADDR, 8'h83);
		settle(20);
		check("gap", gap, 8'h01);
		// external runs already, so switching to it is allowed
		wr_reg(SRC_ADDR, 8'hFF);
		rd_chk(SRC_ADDR, 8'h01);
		settle(40);
		check("gap", gap, 8'h0A);
		wr_reg(SRC_ADDR, 8'h00);
		settle(20);
		check("gap", gap, 8'h01);
		// reset in mid-run while the external source clocks the core
		wr_reg(SRC_ADDR, 8'h01);
		settle(20);
		rst_b_in = 1'b0;
		settle(2);
		rst_b_in = 1'b1;
		rd_chk(SRC_ADDR, 8'h00);
		rd_chk(CTRL_ADDR, 8'hC0);
		settle(20);
		check("gap", gap, 8'h08);
		tally_and_finish();
	end
endmodule
`default_nettype wire
